/* File: bench/uart_register_access_port_tb_top.sv */
// Self-checking bench of the serial register access port
`timescale 1ns/10ps
module uart_register_access_port_tb_top;
    localparam int BOOT = 20;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic uart_rx;
    logic uart_tx;
    logic fan_mode_jumper = 1'b0;
    logic [7:0] cpu_temp = 8'h20;
    logic [15:0] fan_rpm = 16'h0000;
    logic fan_fault = 1'b0;
    logic [7:0] fan_duty;
    logic app_running;
    logic i2c_pmu_disable;
    int n_fail = 0;
    int tests_run = 0;

    always #10 ref_clk = ~ref_clk;

    urap_top #(.BOOT_CYCLES(BOOT)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .uart_rx(uart_rx), .uart_tx(uart_tx),
        .fan_mode_jumper(fan_mode_jumper), .cpu_temp(cpu_temp), .fan_rpm(fan_rpm),
        .fan_fault(fan_fault), .fan_duty(fan_duty), .app_running(app_running),
        .i2c_pmu_disable(i2c_pmu_disable)
    );

    urap_host host (.ref_clk(ref_clk), .dev_tx(uart_tx), .host_tx(uart_rx));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_chars(input int n);
        int i;
        for (i = 0; i < 30000 && host.rx_chars.size() < n; i++) begin
            @(negedge ref_clk);
        end
        if (host.rx_chars.size() < n) begin
            $display("BAD answer characters expected %0d seen %0d", n, host.rx_chars.size());
            n_fail++;
            conclude();
        end
    endtask

    task automatic t_reset_boot();
        @(negedge ref_clk);
        check("uart_tx in reset", 16'h0001, {15'h0000, uart_tx});
        check("fan_duty in reset", 16'h00FF, {8'h00, fan_duty});
        check("i2c_pmu_disable in reset", 16'h0000, {15'h0000, i2c_pmu_disable});
        @(negedge ref_clk);
        nrst = 1'b1;
        repeat (BOOT / 2) @(negedge ref_clk);
        check("app_running during boot", 16'h0000, {15'h0000, app_running});
        repeat (BOOT) @(negedge ref_clk);
        check("app_running after boot", 16'h0001, {15'h0000, app_running});
    endtask

    // Two-byte read of the fan speed, low byte first
    task automatic t_fan_read();
        logic [7:0] exp_b[2];
        fan_rpm = 16'h0C15;
        exp_b[0] = fan_rpm[7:0];
        exp_b[1] = fan_rpm[15:8];
        host.request(7'h04, 1'b1, 8'h02);
        wait_chars(4);
        for (int i = 0; i < 2; i++) begin
            check("answer high nibble", {8'h00, host.hex_char(exp_b[i][7:4])},
                  {8'h00, host.rx_chars[2 * i]});
            check("answer low nibble", {8'h00, host.hex_char(exp_b[i][3:0])},
                  {8'h00, host.rx_chars[2 * i + 1]});
        end
        check("answer frame errors", 16'h0000, host.frame_errs[15:0]);
    endtask

    // Write of the control register sets the I2C disable bit
    task automatic t_ctrl_write();
        int i;
        // Let the last answer stop bit run out before the next request
        repeat (host.BIT_CYC) @(negedge ref_clk);
        // One byte, and the last request of the run
        host.request(7'h0F, 1'b0, 8'h01);
        host.send_byte(8'h01);
        for (i = 0; i < 2000 && i2c_pmu_disable !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        check("i2c_pmu_disable after write", 16'h0001, {15'h0000, i2c_pmu_disable});
        if (i2c_pmu_disable !== 1'b1) begin
            conclude();
        end
        check("no answer to write", 16'h0004, 16'(host.rx_chars.size()));
    endtask

    // Automatic fan law against temperature, and full speed without jumper
    task automatic t_fan_mode();
        logic [7:0] temps[3] = '{8'h10, 8'h30, 8'h58};
        logic [7:0] duty[3] = '{8'h40, 8'h60, 8'hFF};
        fan_mode_jumper = 1'b1;
        for (int i = 0; i < 3; i++) begin
            cpu_temp = temps[i];
            repeat (4) @(negedge ref_clk);
            check("fan_duty automatic", {8'h00, duty[i]}, {8'h00, fan_duty});
        end
        cpu_temp = 8'h10;
        fan_mode_jumper = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("fan_duty without jumper", 16'h00FF, {8'h00, fan_duty});
    endtask

    initial begin
        t_reset_boot();
        t_fan_read();
        t_ctrl_write();
        t_fan_mode();
        conclude();
    end
endmodule

/* File: bench/urap_host.sv */
// Host computer model: sends hex requests on the serial line, collects answers
`timescale 1ns/10ps
`include "urap_defs.svh"
module urap_host (
    input wire logic ref_clk,
    input wire logic dev_tx,
    output logic host_tx
);
    localparam int BIT_CYC = `URAP_BAUD_DIV;
    logic [7:0] rx_chars[$];
    int frame_errs = 0;

    // Idle line level is high
    initial host_tx = 1'b1;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction

    // Start, 8 data bits LSB first, even parity, one stop bit
    task automatic send_char(input logic [7:0] ch);
        logic [10:0] frame;
        frame = {1'b1, ^ch, ch, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge ref_clk);
            host_tx = frame[i];
            repeat (BIT_CYC - 1) @(negedge ref_clk);
        end
    endtask

    // Two characters per byte, high nibble first
    task automatic send_byte(input logic [7:0] b);
        send_char(hex_char(b[7:4]));
        send_char(hex_char(b[3:0]));
    endtask

    // Address byte with read flag in bit 0, then count byte
    task automatic request(input logic [6:0] addr, input logic rd, input logic [7:0] cnt);
        send_byte({addr, rd});
        send_byte(cnt);
    endtask

    // Receiver samples each bit mid-way
    always begin : rx_proc
        logic [9:0] bits;
        @(negedge dev_tx);
        repeat (BIT_CYC / 2) @(negedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CYC) @(negedge ref_clk);
            bits[i] = dev_tx;
        end
        if (bits[9] !== 1'b1 || ^bits[8:0] !== 1'b0) begin
            frame_errs++;
        end
        rx_chars.push_back(bits[7:0]);
    end
endmodule

/* File: core/urap_defs.svh */
// Constants of the serial register access port: offsets, fields, resets, timing
`ifndef URAP_DEFS_SVH
`define URAP_DEFS_SVH

`define URAP_CLK_HZ 50000000
`define URAP_BAUD_HZ 115200
`define URAP_BAUD_DIV (`URAP_CLK_HZ / `URAP_BAUD_HZ)
`define URAP_BAUD_HALF (`URAP_BAUD_DIV / 2)
`define URAP_DATA_BITS 8
`define URAP_BOOT_US 1000
`define URAP_BOOT_CYC (`URAP_BOOT_US * (`URAP_CLK_HZ / 1000000))

`define URAP_ADR_ID 7'h00
`define URAP_ADR_FWVER 7'h01
`define URAP_ADR_SCRATCH 7'h02
`define URAP_ADR_TEMP 7'h03
`define URAP_ADR_FAN_LO 7'h04
`define URAP_ADR_FAN_HI 7'h05
`define URAP_ADR_FAULT 7'h06
`define URAP_ADR_CTRL 7'h0F

`define URAP_RW_BIT 0
`define URAP_CTRL_CLR_BIT 1
`define URAP_CTRL_I2C_BIT 0
`define URAP_SCRATCH_RST 8'h00
`define URAP_ID_VAL 8'h00

`define URAP_DUTY_FULL 8'hFF
`define URAP_DUTY_MIN 8'h40
`define URAP_TEMP_LO 8'h28
`define URAP_TEMP_HI 8'h58

`endif

/* File: core/urap_if.sv */
// Character link between the command engine and the serial line module
`timescale 1ns/10ps
interface urap_if;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_perr;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    modport core (input rx_valid, input rx_data, input rx_perr, input tx_ready,
                  output tx_valid, output tx_data);
    modport phy (output rx_valid, output rx_data, output rx_perr, output tx_ready,
                 input tx_valid, input tx_data);
endinterface

/* File: core/urap_pkg.sv */
// Types of the serial register access port
package urap_pkg;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} urap_rx_st_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} urap_tx_st_t;
    typedef enum logic [2:0] {CS_BOOT, CS_ADDR, CS_COUNT, CS_WDATA, CS_RDATA} urap_cmd_st_t;
endpackage

/* File: core/urap_top.sv */
// Register access port of the board management controller, hex over serial
// Operation
// RL1 - First byte: address in bits 7-1, bit 0 one for read, zero for write.
// RL2 - Host follows with a count of consecutive register bytes to transfer.
// RL3 - A read returns exactly count bytes from consecutive addresses.
// RL4 - Sixteen-bit fan speed goes least significant byte first.
// RL5 - Link runs 115200 baud, eight data bits, even parity, one stop bit.
// RL6 - Jumper fitted regulates fan from temperature; absent runs fan at full.
// RL7 - After power-up a boot phase runs, then the register service starts.
// RL8 - Every byte travels as two ASCII hex characters, high nibble first.
// RL9 - Host sends exactly count data bytes on a write, else the port waits.
// RL10 - Writes total at most 256 bytes; host then waits 100 ms.
`timescale 1ns/10ps
`include "urap_defs.svh"
module urap_top #(
    parameter int BOOT_CYCLES = `URAP_BOOT_CYC,
    parameter logic [7:0] FW_VERSION = 8'h10 // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic uart_rx,
    output logic uart_tx,
    input wire logic fan_mode_jumper,
    input wire logic [7:0] cpu_temp,
    input wire logic [15:0] fan_rpm,
    input wire logic fan_fault,
    output logic [7:0] fan_duty,
    output logic app_running,
    output logic i2c_pmu_disable
);
    urap_if link ();

    urap_uart u_uart (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .uart_rx(uart_rx),
        .uart_tx(uart_tx),
        .link(link.phy)
    );

    urap_pkg::urap_cmd_st_t st_q;
    logic [31:0] boot_cnt_q;
    logic [6:0] addr_q;
    logic [7:0] cnt_q;
    logic [3:0] nib_hi_q;
    logic half_q;
    logic byte_stb_q;
    logic [7:0] byte_q;
    logic phase_q;
    logic [7:0] rbyte_q;
    logic [7:0] rd_data;
    logic [7:0] scratch_q;
    logic clr_q;
    logic fault_q;
    logic [7:0] fan_hi_q;
    logic [4:0] rx_nib;
    logic push_valid;
    logic push_ready;
    logic push_go;
    logic [7:0] push_data;
    logic [7:0] buf_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] fill_q;
    logic pop_go;
    logic wr_stb;

    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            return {1'b1, 4'(c - 8'h30)};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            return {1'b1, 4'(c - 8'h37)};
        end else if (c >= 8'h61 && c <= 8'h66) begin
            return {1'b1, 4'(c - 8'h57)};
        end
        return 5'h00;
    endfunction

    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // Boot phase, then hand over to the register service
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            boot_cnt_q <= 32'h0000_0000;
        end else if (st_q == urap_pkg::CS_BOOT) begin
            boot_cnt_q <= boot_cnt_q + 32'h0000_0001; // RL7
        end
    end
    assign app_running = (st_q != urap_pkg::CS_BOOT);

    // Pair ASCII characters into bytes
    assign rx_nib = hex_val(link.rx_data);
    always_ff @(posedge ref_clk) begin
        byte_stb_q <= 1'b0;
        if (!nrst) begin
            half_q <= 1'b0;
            nib_hi_q <= 4'h0;
            byte_q <= 8'h00;
        end else if (link.rx_perr || st_q == urap_pkg::CS_RDATA
                     || st_q == urap_pkg::CS_BOOT) begin
            half_q <= 1'b0;
        end else if (link.rx_valid && rx_nib[4]) begin
            if (!half_q) begin
                nib_hi_q <= rx_nib[3:0];
                half_q <= 1'b1;
            end else begin
                byte_q <= {nib_hi_q, rx_nib[3:0]}; // RL8
                byte_stb_q <= 1'b1;
                half_q <= 1'b0;
            end
        end
    end

    // Request sequencer
    assign push_valid = (st_q == urap_pkg::CS_RDATA);
    assign push_go = push_valid && push_ready;
    assign push_data = phase_q ? hex_chr(rbyte_q[3:0]) : hex_chr(rd_data[7:4]); // RL8
    assign wr_stb = (st_q == urap_pkg::CS_WDATA) && byte_stb_q;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_q <= urap_pkg::CS_BOOT;
            addr_q <= 7'h00;
            cnt_q <= 8'h00;
            phase_q <= 1'b0;
            rbyte_q <= 8'h00;
        end else begin
            case (st_q)
                urap_pkg::CS_BOOT: begin
                    if (boot_cnt_q >= 32'(BOOT_CYCLES - 1)) begin
                        st_q <= urap_pkg::CS_ADDR; // RL7
                    end
                end
                urap_pkg::CS_ADDR: begin
                    if (byte_stb_q) begin
                        addr_q <= byte_q[7:1]; // RL1
                        phase_q <= byte_q[`URAP_RW_BIT];
                        st_q <= urap_pkg::CS_COUNT;
                    end
                end
                urap_pkg::CS_COUNT: begin
                    if (byte_stb_q) begin
                        cnt_q <= byte_q; // RL2
                        phase_q <= 1'b0;
                        if (byte_q == 8'h00) begin
                            st_q <= urap_pkg::CS_ADDR;
                        end else if (phase_q) begin
                            st_q <= urap_pkg::CS_RDATA;
                        end else begin
                            st_q <= urap_pkg::CS_WDATA;
                        end
                    end
                end
                urap_pkg::CS_WDATA: begin
                    // Waits here until count data bytes arrive
                    if (byte_stb_q) begin // RL9
                        addr_q <= addr_q + 7'h01;
                        cnt_q <= cnt_q - 8'h01;
                        if (cnt_q == 8'h01) begin
                            st_q <= urap_pkg::CS_ADDR;
                        end
                    end
                end
                urap_pkg::CS_RDATA: begin
                    if (push_go) begin
                        phase_q <= !phase_q;
                        if (!phase_q) begin
                            rbyte_q <= rd_data;
                        end else begin
                            addr_q <= addr_q + 7'h01; // RL3
                            cnt_q <= cnt_q - 8'h01;
                            if (cnt_q == 8'h01) begin
                                st_q <= urap_pkg::CS_ADDR;
                            end
                        end
                    end
                end
                default: st_q <= urap_pkg::CS_ADDR;
            endcase
        end
    end

    // Register read mux
    always_comb begin
        case (addr_q)
            `URAP_ADR_ID: rd_data = `URAP_ID_VAL;
            `URAP_ADR_FWVER: rd_data = FW_VERSION;
            `URAP_ADR_SCRATCH: rd_data = scratch_q;
            `URAP_ADR_TEMP: rd_data = cpu_temp;
            `URAP_ADR_FAN_LO: rd_data = fan_rpm[7:0]; // RL4
            `URAP_ADR_FAN_HI: rd_data = fan_hi_q; // RL4
            `URAP_ADR_FAULT: rd_data = {7'h00, fault_q};
            `URAP_ADR_CTRL: rd_data = {6'h00, clr_q, i2c_pmu_disable};
            default: rd_data = 8'h00;
        endcase
    end

    // High byte frozen when the low byte goes out, so the pair never tears
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fan_hi_q <= 8'h00;
        end else if (st_q != urap_pkg::CS_RDATA
                     || (push_go && !phase_q && addr_q == `URAP_ADR_FAN_LO)) begin
            fan_hi_q <= fan_rpm[15:8]; // RL4
        end
    end

    // Writable registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            scratch_q <= `URAP_SCRATCH_RST;
            i2c_pmu_disable <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            clr_q <= 1'b0;
            if (wr_stb && addr_q == `URAP_ADR_SCRATCH) begin
                scratch_q <= byte_q;
            end
            if (wr_stb && addr_q == `URAP_ADR_CTRL) begin
                i2c_pmu_disable <= byte_q[`URAP_CTRL_I2C_BIT];
                clr_q <= byte_q[`URAP_CTRL_CLR_BIT];
            end
        end
    end

    // Sticky fault; a new fault wins over the clear
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fault_q <= 1'b0;
        end else if (fan_fault) begin
            fault_q <= 1'b1;
        end else if (clr_q) begin
            fault_q <= 1'b0;
        end
    end

    // Fan drive
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fan_duty <= `URAP_DUTY_FULL;
        end else if (!fan_mode_jumper || cpu_temp >= `URAP_TEMP_HI) begin
            fan_duty <= `URAP_DUTY_FULL; // RL6
        end else if (cpu_temp < `URAP_TEMP_LO) begin
            fan_duty <= `URAP_DUTY_MIN; // RL6
        end else begin
            fan_duty <= `URAP_DUTY_MIN + 8'((cpu_temp - `URAP_TEMP_LO) << 2); // RL6
        end
    end

    // Two-entry transmit buffer
    assign push_ready = (fill_q != 2'h2);
    assign pop_go = link.tx_valid && link.tx_ready;
    assign link.tx_valid = (fill_q != 2'h0);
    assign link.tx_data = buf_q[rp_q];

    for (genvar e = 0; e < 2; e++) begin : g_buf
        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                buf_q[e] <= 8'h00;
            end else if (push_go && wp_q == 1'(e)) begin
                buf_q[e] <= push_data;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            fill_q <= 2'h0;
        end else begin
            wp_q <= wp_q ^ push_go;
            rp_q <= rp_q ^ pop_go;
            fill_q <= fill_q + {1'b0, push_go} - {1'b0, pop_go};
        end
    end

    addr_decode_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL1
        (st_q == urap_pkg::CS_ADDR && byte_stb_q)
        |=> addr_q == $past(byte_q[7:1]) && st_q == urap_pkg::CS_COUNT)
        else $error("address byte decoded wrongly");
    read_dir_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL1
        (st_q == urap_pkg::CS_COUNT && byte_stb_q && byte_q != 8'h00 && phase_q)
        |=> st_q == urap_pkg::CS_RDATA && cnt_q == $past(byte_q))
        else $error("read request did not start a read");
    read_count_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL3
        (push_go && phase_q)
        |=> cnt_q == $past(cnt_q) - 8'h01 && addr_q == $past(addr_q) + 7'h01)
        else $error("read byte count or address not advanced");
    read_end_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL3
        (push_go && phase_q && cnt_q == 8'h01) |=> st_q == urap_pkg::CS_ADDR)
        else $error("read did not stop after the last byte");
    lsb_first_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL4
        (push_go && !phase_q && addr_q == `URAP_ADR_FAN_LO)
        |-> push_data == hex_chr(fan_rpm[7:4]))
        else $error("fan speed low byte not sent first");
    low_nibble_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL8
        (push_go && !phase_q) ##1 (push_valid && phase_q)
        |-> push_data == hex_chr($past(rd_data[3:0], 1)))
        else $error("second character is not the low nibble");
    fan_full_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL6
        !fan_mode_jumper |=> fan_duty == 8'hFF)
        else $error("fan not at full speed without jumper");
    fan_cool_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL6
        (fan_mode_jumper && cpu_temp < 8'h28) |=> fan_duty == 8'h40)
        else $error("fan not at minimum when cool");
    boot_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL7
        app_running |-> boot_cnt_q >= 32'(BOOT_CYCLES - 1))
        else $error("service started before boot phase ended");
    buf_full_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fill_q == 2'h2 && !pop_go) |=> fill_q == 2'h2 && !push_ready)
        else $error("full buffer accepted a character");
endmodule

/* File: core/urap_uart.sv */
// Serial line module: 8 data bits, even parity, one stop bit
`timescale 1ns/10ps
`include "urap_defs.svh"
module urap_uart (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic uart_rx,
    output logic uart_tx,
    urap_if.phy link
);
    localparam logic [8:0] DIV_M1 = 9'(`URAP_BAUD_DIV - 1);
    localparam logic [8:0] HALF_M1 = 9'(`URAP_BAUD_HALF - 1);
    localparam logic [2:0] LAST_BIT = 3'(`URAP_DATA_BITS - 1);

    urap_pkg::urap_rx_st_t rx_st_q;
    urap_pkg::urap_tx_st_t tx_st_q;
    logic [8:0] rx_div_q;
    logic [8:0] tx_div_q;
    logic [2:0] rx_bit_q;
    logic [2:0] tx_bit_q;
    logic [7:0] rx_sh_q;
    logic [7:0] tx_sh_q;
    logic [7:0] tx_byte_q;
    logic rx_par_q;
    logic rx_valid_q;
    logic rx_perr_q;

    assign link.rx_valid = rx_valid_q;
    assign link.rx_data = rx_sh_q;
    assign link.rx_perr = rx_perr_q;
    assign link.tx_ready = (tx_st_q == urap_pkg::TX_IDLE);

    // Receiver, sampled at mid bit
    always_ff @(posedge ref_clk) begin
        rx_valid_q <= 1'b0;
        rx_perr_q <= 1'b0;
        if (!nrst) begin
            rx_st_q <= urap_pkg::RX_IDLE;
            rx_div_q <= 9'h000;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_par_q <= 1'b0;
        end else if (rx_st_q == urap_pkg::RX_IDLE) begin
            if (!uart_rx) begin
                rx_st_q <= urap_pkg::RX_START;
                rx_div_q <= HALF_M1;
            end
        end else if (rx_div_q != 9'h000) begin
            rx_div_q <= rx_div_q - 9'h001;
        end else begin
            rx_div_q <= DIV_M1;
            case (rx_st_q)
                urap_pkg::RX_START: begin
                    rx_st_q <= uart_rx ? urap_pkg::RX_IDLE : urap_pkg::RX_DATA;
                    rx_bit_q <= 3'h0;
                end
                urap_pkg::RX_DATA: begin
                    rx_sh_q <= {uart_rx, rx_sh_q[7:1]};
                    rx_bit_q <= rx_bit_q + 3'h1;
                    if (rx_bit_q == LAST_BIT) begin
                        rx_st_q <= urap_pkg::RX_PAR;
                    end
                end
                urap_pkg::RX_PAR: begin
                    rx_par_q <= uart_rx;
                    rx_st_q <= urap_pkg::RX_STOP;
                end
                urap_pkg::RX_STOP: begin
                    // Even parity and a high stop bit, else the character is dropped
                    if (uart_rx && !(^{rx_sh_q, rx_par_q})) begin // RL5
                        rx_valid_q <= 1'b1;
                    end else begin
                        rx_perr_q <= 1'b1;
                    end
                    rx_st_q <= urap_pkg::RX_IDLE;
                end
                default: rx_st_q <= urap_pkg::RX_IDLE;
            endcase
        end
    end

    // Transmitter
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_st_q <= urap_pkg::TX_IDLE;
            tx_div_q <= 9'h000;
            tx_bit_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_byte_q <= 8'h00;
            uart_tx <= 1'b1;
        end else if (tx_st_q == urap_pkg::TX_IDLE) begin
            if (link.tx_valid) begin
                tx_sh_q <= link.tx_data;
                tx_byte_q <= link.tx_data;
                tx_div_q <= DIV_M1;
                tx_st_q <= urap_pkg::TX_START;
                uart_tx <= 1'b0;
            end
        end else if (tx_div_q != 9'h000) begin
            tx_div_q <= tx_div_q - 9'h001;
        end else begin
            tx_div_q <= DIV_M1;
            case (tx_st_q)
                urap_pkg::TX_START: begin
                    uart_tx <= tx_sh_q[0];
                    tx_bit_q <= 3'h0;
                    tx_st_q <= urap_pkg::TX_DATA;
                end
                urap_pkg::TX_DATA: begin
                    if (tx_bit_q == LAST_BIT) begin
                        uart_tx <= ^tx_byte_q; // RL5
                        tx_st_q <= urap_pkg::TX_PAR;
                    end else begin
                        uart_tx <= tx_sh_q[1];
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 3'h1;
                    end
                end
                urap_pkg::TX_PAR: begin
                    uart_tx <= 1'b1;
                    tx_st_q <= urap_pkg::TX_STOP;
                end
                default: tx_st_q <= urap_pkg::TX_IDLE;
            endcase
        end
    end

    rx_parity_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL5
        link.rx_valid |-> !(^{link.rx_data, rx_par_q}))
        else $error("accepted character fails even parity");
    tx_start_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL5
        (tx_st_q == urap_pkg::TX_IDLE && link.tx_valid) |=> !uart_tx [*8])
        else $error("start bit not held low");
    tx_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL5
        (tx_st_q == urap_pkg::TX_PAR && tx_div_q == 9'h000) |=> uart_tx [*8])
        else $error("stop bit not high");
endmodule
